/* File: hw/bms_port.sv */
// Purpose: Port A and port B datapath with bus matching and byte swapping.
// Assumes: Port clocks are slow enough to be sampled and edge-detected by clock.
// Notes: Port B input and output buses are separate; both size high writes are ignored.
`timescale 1ns/1ps
`include "bms_params.svh"

module bms_port #(
  parameter int DEPTH = `BMS_QUEUE_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_en,
  input wire logic port_a_clock,
  input wire logic port_a_write,
  input wire logic port_a_read,
  input wire logic port_a_mail_sel,
  input wire logic [`BMS_DATA_W-1:0] port_a_wdata,
  output logic [`BMS_DATA_W-1:0] port_a_rdata,
  output logic port_a_empty_n,
  output logic port_a_full_n,
  input wire logic port_b_clock,
  input wire logic port_b_write,
  input wire logic port_b_read,
  input wire logic port_b_size_low,
  input wire logic port_b_size_high,
  input wire logic swap_mode_low_bit,
  input wire logic swap_mode_high_bit,
  input wire logic port_b_big_endian,
  input wire logic [`BMS_DATA_W-1:0] port_b_wdata,
  output logic [`BMS_DATA_W-1:0] port_b_rdata,
  output logic port_b_empty_n,
  output logic port_b_full_n
);
  import bms_pkg::*;

  localparam int CW = $clog2(DEPTH+1);

  bms_pkg::bms_state_t st_ff;
  bms_pkg::bms_state_t nxt_st;
  logic a_edge, a_wr, a_rd, a_mb;
  logic b_edge, b_wr, b_rd, b_big;
  logic [1:0] b_size, b_swap, bidx, widx;
  logic [`BMS_DATA_W-1:0] a_din, b_din, lw_swap, asm_next;
  logic a2b_push, a2b_ready, a2b_valid, a2b_pop;
  logic b2a_push, b2a_ready, b2a_valid, b2a_pop;
  logic [`BMS_DATA_W-1:0] a2b_data, b2a_data;
  logic [CW-1:0] a2b_cnt, b2a_cnt;
  logic rd_take, rd_last, mb_take, wr_take, wr_last, b_drain, a_drain;

  // ************************************************************
  // Queues
  // ************************************************************
  bms_fifo #(.WIDTH(`BMS_DATA_W), .DEPTH(DEPTH)) u_a_to_b_queue (
    .clock(clock),
    .rst_n(rst_n),
    .clock_en(clock_en),
    .in_valid(a2b_push),
    .in_ready(a2b_ready),
    .in_data(a_din),
    .out_valid(a2b_valid),
    .out_ready(a2b_pop),
    .out_data(a2b_data),
    .count(a2b_cnt)
  );

  bms_fifo #(.WIDTH(`BMS_DATA_W), .DEPTH(DEPTH)) u_b_to_a_queue (
    .clock(clock),
    .rst_n(rst_n),
    .clock_en(clock_en),
    .in_valid(b2a_push),
    .in_ready(b2a_ready),
    .in_data(bms_swap(asm_next, b_swap)),
    .out_valid(b2a_valid),
    .out_ready(b2a_pop),
    .out_data(b2a_data),
    .count(b2a_cnt)
  );

  // ************************************************************
  // Sampled pins and port clock edges
  // ************************************************************
  // Fields come from the second synchroniser stage only.
  assign a_edge = st_ff.a_s2[`BMS_A_CLK] & ~st_ff.a_clk_prev;
  assign a_wr = st_ff.a_s2[`BMS_A_WR];
  assign a_rd = st_ff.a_s2[`BMS_A_RD];
  assign a_mb = st_ff.a_s2[`BMS_A_MB];
  assign a_din = st_ff.a_s2[`BMS_DATA_W-1:0];
  assign b_edge = st_ff.b_s2[`BMS_B_CLK] & ~st_ff.b_clk_prev;
  assign b_wr = st_ff.b_s2[`BMS_B_WR];
  assign b_rd = st_ff.b_s2[`BMS_B_RD];
  assign b_size = st_ff.b_s2[`BMS_B_SIZ +: 2];
  assign b_swap = st_ff.b_s2[`BMS_B_SW +: 2];
  assign b_big = st_ff.b_s2[`BMS_B_BE];
  assign b_din = st_ff.b_s2[`BMS_DATA_W-1:0];

  // ************************************************************
  // Transfer decode
  // ************************************************************
  // A long word is released or accepted only on its final piece.
  assign lw_swap = bms_swap(a2b_data, b_swap);
  assign mb_take = b_edge & b_rd & (b_size == `BMS_SIZE_MAIL);
  assign rd_take = b_edge & b_rd & st_ff.b_empty_n & (b_size != `BMS_SIZE_MAIL);
  assign rd_last = (b_size == `BMS_SIZE_LONG)
                 | ((b_size == `BMS_SIZE_WORD) & st_ff.rphase[0])
                 | ((b_size == `BMS_SIZE_BYTE) & (st_ff.rphase == 2'h3));
  assign a2b_pop = rd_take & rd_last;
  assign b_drain = a2b_pop & (a2b_cnt == CW'(1));
  assign wr_take = b_edge & b_wr & st_ff.b_full_n & (b_size != `BMS_SIZE_MAIL);
  assign wr_last = (b_size == `BMS_SIZE_LONG)
                 | ((b_size == `BMS_SIZE_WORD) & st_ff.wphase[0])
                 | ((b_size == `BMS_SIZE_BYTE) & (st_ff.wphase == 2'h3));
  assign b2a_push = wr_take & wr_last;
  assign a2b_push = a_edge & a_wr & ~a_mb & st_ff.a_full_n;
  assign b2a_pop = a_edge & a_rd & st_ff.a_empty_n;
  assign a_drain = b2a_pop & (b2a_cnt == CW'(1));
  assign bidx = b_big ? 2'h3 - st_ff.rphase : st_ff.rphase;
  assign widx = b_big ? 2'h3 - st_ff.wphase : st_ff.wphase;

  // Assembly of the next B-to-A long word from the current piece.
  always_comb begin
    asm_next = st_ff.asm_word;
    case (b_size)
      `BMS_SIZE_WORD: begin
        if (b_big ^ st_ff.wphase[0]) begin
          asm_next[35:18] = b_big ? b_din[35:18] : b_din[17:0];
        end else begin
          asm_next[17:0] = b_big ? b_din[35:18] : b_din[17:0];
        end
      end
      `BMS_SIZE_BYTE: begin
        asm_next[9*widx +: 9] = b_big ? b_din[35:27] : b_din[8:0];
      end
      default: asm_next = b_din;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.a_s1 = {port_a_clock, port_a_write, port_a_read, port_a_mail_sel, port_a_wdata};
    nxt_st.a_s2 = st_ff.a_s1;
    nxt_st.a_clk_prev = st_ff.a_s2[`BMS_A_CLK];
    nxt_st.b_s1 = {port_b_clock, port_b_write, port_b_read, port_b_size_high,
                   port_b_size_low, swap_mode_high_bit, swap_mode_low_bit,
                   port_b_big_endian, port_b_wdata};
    nxt_st.b_s2 = st_ff.b_s1;
    nxt_st.b_clk_prev = st_ff.b_s2[`BMS_B_CLK];
    // Port A side: mailbox load, queue read and its flags.
    if (a_edge) begin
      if (a_wr & a_mb) begin
        nxt_st.mailbox = a_din;
      end
      if (b2a_pop) begin
        nxt_st.a_rdata = b2a_data;
      end
      nxt_st.a_sync = b2a_valid & ~a_drain;
      nxt_st.a_empty_n = a_drain ? 1'b0 : st_ff.a_sync;
      nxt_st.a_full_n = a2b_ready;
    end
    // Port B reads: mailbox, long word, word or byte pieces.
    if (mb_take) begin
      nxt_st.b_rdata = st_ff.mailbox;
    end else if (rd_take) begin
      case (b_size)
        `BMS_SIZE_WORD: begin
          if (b_big) begin
            nxt_st.b_rdata[35:18] = st_ff.rphase[0] ? lw_swap[17:0] : lw_swap[35:18];
          end else begin
            nxt_st.b_rdata[17:0] = st_ff.rphase[0] ? lw_swap[35:18] : lw_swap[17:0];
          end
        end
        `BMS_SIZE_BYTE: begin
          if (b_big) begin
            nxt_st.b_rdata[35:27] = lw_swap[9*bidx +: 9];
          end else begin
            nxt_st.b_rdata[8:0] = lw_swap[9*bidx +: 9];
          end
        end
        default: nxt_st.b_rdata = lw_swap;
      endcase
      nxt_st.rphase = rd_last ? `BMS_PHASE_RST : st_ff.rphase + 2'h1;
    end
    // Port B writes: pieces gather until the last one completes the word.
    if (wr_take) begin
      nxt_st.asm_word = asm_next;
      nxt_st.wphase = wr_last ? `BMS_PHASE_RST : st_ff.wphase + 2'h1;
    end
    // Port B empty follows the A-to-B queue through two port B stages; full follows the B-to-A queue in one.
    if (b_edge) begin
      nxt_st.b_sync = a2b_valid & ~b_drain;
      nxt_st.b_empty_n = b_drain ? 1'b0 : st_ff.b_sync;
      nxt_st.b_full_n = b2a_ready;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clock_en) begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign port_a_rdata = st_ff.a_rdata;
  assign port_a_empty_n = st_ff.a_empty_n;
  assign port_a_full_n = st_ff.a_full_n;
  assign port_b_rdata = st_ff.b_rdata;
  assign port_b_empty_n = st_ff.b_empty_n;
  assign port_b_full_n = st_ff.b_full_n;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_long_read;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      (rd_take && b_size == `BMS_SIZE_LONG) |=> (port_b_rdata == $past(lw_swap));
  endproperty
  a_long_read: assert property (p_long_read) else $error("long read data wrong");

  property p_word_hold;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      (rd_take && b_size == `BMS_SIZE_WORD && b_big) |=> $stable(port_b_rdata[17:0]);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("unused word half changed");

  property p_byte_hold;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      (rd_take && b_size == `BMS_SIZE_BYTE && !b_big) |=> $stable(port_b_rdata[35:9]);
  endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("unused byte lanes changed");

  property p_mailbox;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      mb_take |=> (port_b_rdata == $past(st_ff.mailbox));
  endproperty
  a_mailbox: assert property (p_mailbox) else $error("mailbox read data wrong");

  property p_empty_fall;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      $fell(port_b_empty_n) |-> $past(rd_take && rd_last);
  endproperty
  a_empty_fall: assert property (p_empty_fall) else $error("empty before last piece");

  property p_b_rise;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      (a2b_valid && !port_b_empty_n) |-> ##[1:40] port_b_empty_n;
  endproperty
  a_b_rise: assert property (p_b_rise) else $error("port B empty flag did not rise");

  property p_a_rise;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      (b2a_valid && !port_a_empty_n) |-> ##[1:40] port_a_empty_n;
  endproperty
  a_a_rise: assert property (p_a_rise) else $error("port A empty flag did not rise");

  property p_push_last;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      (wr_take && !wr_last && !b2a_pop) |=> (b2a_cnt == $past(b2a_cnt));
  endproperty
  a_push_last: assert property (p_push_last) else $error("partial long word pushed");

  property p_flag_edge;
    @(posedge clock) disable iff (!rst_n || !clock_en)
      $changed(port_b_empty_n) |-> $past(b_edge);
  endproperty
  a_flag_edge: assert property (p_flag_edge) else $error("flag moved off a port B edge");

endmodule

/* File: hw/bms_params.svh */
// Purpose: Constants of the port B bus-matching and byte-swap datapath.
// Assumes: Included by the package and by the design modules.
// Notes: Field positions refer to the sampled pin vectors of the top module.
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH

// Data width of one long word and depth of each queue.
`define BMS_DATA_W 36
`define BMS_QUEUE_DEPTH 8

// Port B size select codes, {port_b_size_high, port_b_size_low}.
`define BMS_SIZE_LONG 2'h0
`define BMS_SIZE_WORD 2'h1
`define BMS_SIZE_BYTE 2'h2
`define BMS_SIZE_MAIL 2'h3

// Swap mode codes, {swap_mode_high_bit, swap_mode_low_bit}.
`define BMS_SWAP_NONE 2'h0
`define BMS_SWAP_FULL 2'h1
`define BMS_SWAP_HALF 2'h2
`define BMS_SWAP_PAIR 2'h3

// Layout of the sampled port A vector.
`define BMS_A_VEC_W 40
`define BMS_A_CLK 39
`define BMS_A_WR 38
`define BMS_A_RD 37
`define BMS_A_MB 36

// Layout of the sampled port B vector.
`define BMS_B_VEC_W 44
`define BMS_B_CLK 43
`define BMS_B_WR 42
`define BMS_B_RD 41
`define BMS_B_SIZ 39
`define BMS_B_SW 37
`define BMS_B_BE 36

// Reset values.
`define BMS_DATA_RST 36'h0
`define BMS_PHASE_RST 2'h0

`endif

/* File: hw/bms_pkg.sv */
// Purpose: Types and the byte swap function of the bus-matching datapath.
// Assumes: Constants come from bms_params.svh.
// Notes: Every swap mode is its own inverse, so one function serves both directions.
`include "bms_params.svh"

package bms_pkg;

  // ************************************************************
  // State of the top module
  // ************************************************************
  typedef struct packed {
    logic [`BMS_A_VEC_W-1:0] a_s1;
    logic [`BMS_A_VEC_W-1:0] a_s2;
    logic a_clk_prev;
    logic [`BMS_B_VEC_W-1:0] b_s1;
    logic [`BMS_B_VEC_W-1:0] b_s2;
    logic b_clk_prev;
    logic [`BMS_DATA_W-1:0] a_rdata;
    logic [`BMS_DATA_W-1:0] b_rdata;
    logic [`BMS_DATA_W-1:0] mailbox;
    logic [`BMS_DATA_W-1:0] asm_word;
    logic [1:0] rphase;
    logic [1:0] wphase;
    logic a_sync;
    logic a_empty_n;
    logic b_sync;
    logic b_empty_n;
    logic a_full_n;
    logic b_full_n;
  } bms_state_t;

  // Reorders the four 9-bit bytes of a long word by swap mode.
  function automatic logic [`BMS_DATA_W-1:0] bms_swap(input logic [`BMS_DATA_W-1:0] w,
                                                      input logic [1:0] m);
    logic [`BMS_DATA_W-1:0] r;
    r = w;
    case (m)
      `BMS_SWAP_FULL: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      `BMS_SWAP_HALF: r = {w[17:0], w[35:18]};
      `BMS_SWAP_PAIR: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: r = w;
    endcase
    return r;
  endfunction

endpackage

/* File: hw/bms_fifo.sv */
// Purpose: Synchronous queue of long words with valid and ready on both sides.
// Assumes: One clock; writer and reader may act in the same cycle.
// Notes: Output data is the head word while out_valid is high.
`timescale 1ns/1ps
`include "bms_params.svh"

module bms_fifo #(
  parameter int WIDTH = `BMS_DATA_W,
  parameter int DEPTH = `BMS_QUEUE_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clock_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  import bms_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
  } bms_fifo_state_t;

  bms_fifo_state_t st_ff;
  bms_fifo_state_t nxt_st;
  logic push;
  logic pop;

  // ************************************************************
  // Flags and head word
  // ************************************************************
  // Full and empty come straight from the occupancy count.
  assign in_ready = (st_ff.cnt != CW'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rptr];
  assign count = st_ff.cnt;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers wrap at the depth so that any depth works.
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wptr] = in_data;
      nxt_st.wptr = (st_ff.wptr == AW'(DEPTH-1)) ? '0 : st_ff.wptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rptr = (st_ff.rptr == AW'(DEPTH-1)) ? '0 : st_ff.rptr + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clock_en) begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* File: tb/bms_host.sv */
// Purpose: Host model that drives the port A and port B buses of the datapath.
// Assumes: Both port clocks run free at 320 ns with phases unrelated to the system clock.
// Notes: A request is held from one falling port clock edge to the next one.
`timescale 1ns/1ps

module bms_host (
  output logic port_a_clock,
  output logic port_a_write,
  output logic port_a_read,
  output logic port_a_mail_sel,
  output logic [35:0] port_a_wdata,
  output logic port_b_clock,
  output logic port_b_write,
  output logic port_b_read,
  output logic port_b_size_low,
  output logic port_b_size_high,
  output logic swap_mode_low_bit,
  output logic swap_mode_high_bit,
  output logic port_b_big_endian,
  output logic [35:0] port_b_wdata
);
  // Port A clock, offset so that it never lines up with the system clock.
  initial begin
    port_a_clock = 1'b0;
    #17;
    forever #160 port_a_clock = ~port_a_clock;
  end

  // Port B clock, with its own offset from port A.
  initial begin
    port_b_clock = 1'b0;
    #97;
    forever #160 port_b_clock = ~port_b_clock;
  end

  // Idle levels at time zero; long-word size selected by default.
  initial begin
    {port_a_write, port_a_read, port_a_mail_sel} = 3'h0;
    {port_b_write, port_b_read} = 2'h0;
    {port_b_size_high, port_b_size_low} = 2'h0;
    {swap_mode_high_bit, swap_mode_low_bit} = 2'h0;
    port_b_big_endian = 1'b0;
    port_a_wdata = 36'h0;
    port_b_wdata = 36'h0;
  end

  // One port A access; returns at the rising edge after release, when read data stands.
  task automatic a_cycle(input logic wr, input logic rd, input logic mb, input logic [35:0] d);
    @(negedge port_a_clock);
    {port_a_write, port_a_read, port_a_mail_sel} = {wr, rd, mb};
    port_a_wdata = d;
    @(negedge port_a_clock);
    {port_a_write, port_a_read, port_a_mail_sel} = 3'h0;
    port_a_wdata = ~d; // A released bus must not keep showing the old value.
    @(posedge port_a_clock);
  endtask

  // One port B access; size, swap mode and lane order stay set after it.
  task automatic b_cycle(input logic wr, input logic rd, input logic [1:0] siz,
                         input logic [1:0] swm, input logic be, input logic [35:0] d);
    @(negedge port_b_clock);
    {port_b_write, port_b_read} = {wr, rd};
    {port_b_size_high, port_b_size_low} = siz;
    {swap_mode_high_bit, swap_mode_low_bit} = swm;
    port_b_big_endian = be;
    port_b_wdata = d;
    @(negedge port_b_clock);
    {port_b_write, port_b_read} = 2'h0;
    port_b_wdata = ~d; // A released bus must not keep showing the old value.
    @(posedge port_b_clock);
  endtask
endmodule

/* File: tb/tb_bus_matching_byte_swap_port.sv */
// Purpose: Self-checking bench of the bus-matching and byte-swap datapath.
// Assumes: Host model drives both ports; queues are built two deep.
// Notes: The bench keeps its own copy of the port B output register.
`timescale 1ns/1ps

module tb_bus_matching_byte_swap_port;
  logic clock, rst_n, clock_en;
  logic pa_clk, pa_wr, pa_rd, pa_mb, pb_clk, pb_wr, pb_rd, be;
  logic pb_sz_lo, pb_sz_hi, pb_swm_lo, pb_swm_hi;
  logic [35:0] pa_wd, pa_rd_d, pb_wd, pb_rd_d;
  logic pa_empty_n, pa_full_n, pb_empty_n, pb_full_n;
  logic [35:0] exp_b, s, d;
  int num_errors = 0;
  int comparisons = 0;
  localparam logic [35:0] LW = {9'h1a1, 9'h0b2, 9'h1c3, 9'h0d4};

  bms_port #(.DEPTH(2)) bms_port_i (.clock(clock), .rst_n(rst_n), .clock_en(clock_en),
    .port_a_clock(pa_clk), .port_a_write(pa_wr), .port_a_read(pa_rd),
    .port_a_mail_sel(pa_mb), .port_a_wdata(pa_wd), .port_a_rdata(pa_rd_d),
    .port_a_empty_n(pa_empty_n), .port_a_full_n(pa_full_n), .port_b_clock(pb_clk),
    .port_b_write(pb_wr), .port_b_read(pb_rd), .port_b_size_low(pb_sz_lo),
    .port_b_size_high(pb_sz_hi), .swap_mode_low_bit(pb_swm_lo),
    .swap_mode_high_bit(pb_swm_hi),
    .port_b_big_endian(be), .port_b_wdata(pb_wd), .port_b_rdata(pb_rd_d),
    .port_b_empty_n(pb_empty_n), .port_b_full_n(pb_full_n));

  bms_host bms_host_i (.port_a_clock(pa_clk), .port_a_write(pa_wr), .port_a_read(pa_rd),
    .port_a_mail_sel(pa_mb), .port_a_wdata(pa_wd), .port_b_clock(pb_clk),
    .port_b_write(pb_wr), .port_b_read(pb_rd), .port_b_size_low(pb_sz_lo),
    .port_b_size_high(pb_sz_hi), .swap_mode_low_bit(pb_swm_lo),
    .swap_mode_high_bit(pb_swm_hi),
    .port_b_big_endian(be), .port_b_wdata(pb_wd));

  // ************************************************************
  // Helpers
  // ************************************************************
  // Byte reorder by swap mode, one case per mode.
  function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] m);
    case (m)
      2'h1: return {w[8:0], w[17:9], w[26:18], w[35:27]};
      2'h2: return {w[17:0], w[35:18]};
      2'h3: return {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: return w;
    endcase
  endfunction

  // Compares a seen value with the expected one and counts both.
  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // System clock at 25 MHz.
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // The tests need well under 100 us; five times that means a hang.
  initial begin
    #500000;
    num_errors++;
    tally_and_finish();
  end

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    rst_n = 1'b0;
    clock_en = 1'b1;
    exp_b = 36'h0;
    repeat (6) @(posedge clock);
    #2;
    rst_n = 1'b1;
    repeat (2) @(posedge pb_clk);
    check("b empty after reset", {35'h0, pb_empty_n}, 36'h0);
    check("a empty after reset", {35'h0, pa_empty_n}, 36'h0);
    check("b data after reset", pb_rd_d, exp_b);
    check("b full after first edge", {35'h0, pb_full_n}, 36'h1);
    check("a full after first edge", {35'h0, pa_full_n}, 36'h1);
    // Long-word reads in every swap mode.
    for (int m = 0; m < 4; m++) begin
      bms_host_i.a_cycle(1'b1, 1'b0, 1'b0, LW ^ 36'(m));
      repeat (3) @(posedge pb_clk);
      check("b empty set", {35'h0, pb_empty_n}, 36'h1);
      bms_host_i.b_cycle(1'b0, 1'b1, 2'h0, m[1:0], 1'b0, 36'h0);
      exp_b = swp(LW ^ 36'(m), m[1:0]);
      check("long read", pb_rd_d, exp_b);
      check("b empty clear", {35'h0, pb_empty_n}, 36'h0);
    end
    // A read of the empty queue leaves the output register alone.
    bms_host_i.b_cycle(1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 36'h0);
    check("refused read", pb_rd_d, exp_b);
    // Word (z=1) and byte (z=2) reads in both lane orders.
    for (int z = 1; z < 3; z++) begin
      for (int e = 0; e < 2; e++) begin
        bms_host_i.a_cycle(1'b1, 1'b0, 1'b0, LW + 36'(z * 4 + e));
        repeat (3) @(posedge pb_clk);
        s = swp(LW + 36'(z * 4 + e), 2'(z + e));
        for (int k = 0; k < z * 2; k++) begin
          bms_host_i.b_cycle(1'b0, 1'b1, 2'(z), 2'(z + e), e[0], 36'h0);
          if (z == 1 && e == 1) exp_b[35:18] = s[35 - 18 * k -: 18];
          if (z == 1 && e == 0) exp_b[17:0] = s[18 * k +: 18];
          if (z == 2 && e == 1) exp_b[35:27] = s[35 - 9 * k -: 9];
          if (z == 2 && e == 0) exp_b[8:0] = s[9 * k +: 9];
          check("piece read", pb_rd_d, exp_b);
          check("piece empty", {35'h0, pb_empty_n}, (k == z * 2 - 1) ? 36'h0 : 36'h1);
        end
      end
    end
    // Mailbox read replaces the whole bus and leaves the queue empty.
    bms_host_i.a_cycle(1'b1, 1'b0, 1'b1, 36'h9_3c5a_e1f7);
    bms_host_i.b_cycle(1'b0, 1'b1, 2'h3, 2'h1, 1'b1, 36'h0);
    exp_b = 36'h9_3c5a_e1f7;
    check("mailbox read", pb_rd_d, exp_b);
    check("mailbox empty", {35'h0, pb_empty_n}, 36'h0);
    // A port A write while the clock enable is low is never seen.
    @(posedge clock);
    #2;
    clock_en = 1'b0;
    bms_host_i.a_cycle(1'b1, 1'b0, 1'b0, LW);
    @(posedge clock);
    #2;
    clock_en = 1'b1;
    repeat (3) @(posedge pb_clk);
    check("frozen write", {35'h0, pb_empty_n}, 36'h0);
    // Fill the two-deep queue until it refuses, then drain it.
    for (int k = 0; k < 3; k++) begin
      bms_host_i.a_cycle(1'b1, 1'b0, 1'b0, LW - 36'(k));
    end
    repeat (2) @(posedge pa_clk);
    check("a full", {35'h0, pa_full_n}, 36'h0);
    for (int k = 0; k < 2; k++) begin
      bms_host_i.b_cycle(1'b0, 1'b1, 2'h0, 2'h0, 1'b0, 36'h0);
      check("drain read", pb_rd_d, LW - 36'(k));
    end
    check("drained", {35'h0, pb_empty_n}, 36'h0);
    // Byte writes in both lane orders, read back whole at port A.
    for (int e = 0; e < 2; e++) begin
      s = swp(LW ^ 36'(e), 2'(3 - 2 * e));
      for (int k = 0; k < 4; k++) begin
        d = e[0] ? {s[35 - 9 * k -: 9], 27'h2a5a5a5} : {27'h2a5a5a5, s[9 * k +: 9]};
        bms_host_i.b_cycle(1'b1, 1'b0, 2'h2, 2'(3 - 2 * e), e[0], d);
        repeat (3) @(posedge pa_clk);
        check("a empty", {35'h0, pa_empty_n}, (k == 3) ? 36'h1 : 36'h0);
      end
      bms_host_i.a_cycle(1'b0, 1'b1, 1'b0, 36'h0);
      check("a read", pa_rd_d, LW ^ 36'(e));
    end
    // Long-word (z=0) and big-endian word (z=1) writes, read back whole at port A.
    for (int z = 0; z < 2; z++) begin
      s = swp(LW - 36'(z), 2'(z + 1));
      for (int k = 0; k <= z; k++) begin
        d = (z == 0) ? s : {s[35 - 18 * k -: 18], 18'h3ffff};
        bms_host_i.b_cycle(1'b1, 1'b0, 2'(z), 2'(z + 1), 1'b1, d);
      end
      repeat (3) @(posedge pa_clk);
      check("a empty whole", {35'h0, pa_empty_n}, 36'h1);
      bms_host_i.a_cycle(1'b0, 1'b1, 1'b0, 36'h0);
      check("a read whole", pa_rd_d, LW - 36'(z));
    end
    tally_and_finish();
  end
endmodule
